// [verilog/monitor_pkg.sv]
package monitor_pkg;

    // ==========================================================
    // sizes
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CODE_W = 16;
    localparam int IDX_W = 4;
    localparam int WORDS = 9;

    // ==========================================================
    // register offsets as printed (word-granular device map)
    localparam logic [11:0] OFS_SPEED_ESTIMATE = 12'h196;
    localparam logic [11:0] OFS_SUPPLY_BUS_CURRENT = 12'h410;
    localparam logic [11:0] OFS_PHASE_A_CURRENT = 12'h440;
    localparam logic [11:0] OFS_PHASE_B_CURRENT = 12'h442;
    localparam logic [11:0] OFS_PHASE_C_CURRENT = 12'h444;
    localparam logic [11:0] OFS_SENSE_AMP_GAIN_CODE = 12'h468;
    localparam logic [11:0] OFS_VOLTAGE_RANGE_CODE = 12'h472;
    localparam logic [11:0] OFS_SUPPLY_VOLTAGE = 12'h474;
    localparam logic [11:0] OFS_PHASE_A_VOLTAGE_DETECT = 12'h47a;

    // ==========================================================
    // storage slot of each register
    localparam logic [3:0] IDX_SPEED_ESTIMATE = 4'h0;
    localparam logic [3:0] IDX_SUPPLY_BUS_CURRENT = 4'h1;
    localparam logic [3:0] IDX_PHASE_A_CURRENT = 4'h2;
    localparam logic [3:0] IDX_PHASE_B_CURRENT = 4'h3;
    localparam logic [3:0] IDX_PHASE_C_CURRENT = 4'h4;
    localparam logic [3:0] IDX_SENSE_AMP_GAIN_CODE = 4'h5;
    localparam logic [3:0] IDX_VOLTAGE_RANGE_CODE = 4'h6;
    localparam logic [3:0] IDX_SUPPLY_VOLTAGE = 4'h7;
    localparam logic [3:0] IDX_PHASE_A_VOLTAGE_DETECT = 4'h8;
    localparam logic [3:0] IDX_NONE = 4'hf;

    // ==========================================================
    // reset values and code meanings
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_CODE = 16'h0000;
    localparam logic [15:0] GAIN_TOP_X8 = 16'h0000;
    localparam logic [15:0] GAIN_TOP_X4 = 16'h0001;
    localparam logic [15:0] GAIN_TOP_X2 = 16'h0002;
    localparam logic [15:0] GAIN_TOP_X1 = 16'h0003;
    localparam logic [15:0] RANGE_60V = 16'h0000;
    localparam logic [15:0] RANGE_30V = 16'h0001;
    localparam logic [15:0] RANGE_15V = 16'h0002;
    localparam int FRAC_BITS = 27;
    localparam int READ_LATENCY = 2;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } host_req_s;

    typedef struct packed {
        logic valid;
        logic [3:0] idx;
        logic [31:0] data;
    } mon_upd_s;

    // ==========================================================
    // offset to slot, IDX_NONE when unmapped
    function automatic logic [3:0] addr_to_idx(input logic [11:0] a);
        logic [3:0] r;
        r = IDX_NONE;
        unique case (a)
            OFS_SPEED_ESTIMATE: r = IDX_SPEED_ESTIMATE;
            OFS_SUPPLY_BUS_CURRENT: r = IDX_SUPPLY_BUS_CURRENT;
            OFS_PHASE_A_CURRENT: r = IDX_PHASE_A_CURRENT;
            OFS_PHASE_B_CURRENT: r = IDX_PHASE_B_CURRENT;
            OFS_PHASE_C_CURRENT: r = IDX_PHASE_C_CURRENT;
            OFS_SENSE_AMP_GAIN_CODE: r = IDX_SENSE_AMP_GAIN_CODE;
            OFS_VOLTAGE_RANGE_CODE: r = IDX_VOLTAGE_RANGE_CODE;
            OFS_SUPPLY_VOLTAGE: r = IDX_SUPPLY_VOLTAGE;
            OFS_PHASE_A_VOLTAGE_DETECT: r = IDX_PHASE_A_VOLTAGE_DETECT;
            default: r = IDX_NONE;
        endcase
        return r;
    endfunction

    // 16-bit code slots
    function automatic logic is_code_idx(input logic [3:0] i);
        return (i == IDX_SENSE_AMP_GAIN_CODE) ||
               (i == IDX_VOLTAGE_RANGE_CODE);
    endfunction

endpackage

// [verilog/monitor_store.sv]
`timescale 1ns/100ps

module monitor_store (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // write port
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [31:0] wr_data,
    // read port, data one cycle after the index
    input wire logic [3:0] rd_idx,
    output logic [31:0] rd_data
);

    // ==========================================================
    // storage
    logic [31:0] mem_reg [monitor_pkg::WORDS];
    logic [31:0] mem_next [monitor_pkg::WORDS];
    logic [31:0] rd_data_reg;
    logic [31:0] rd_data_next;

    // next contents; a read in the write cycle sees the old word
    always_comb begin
        for (int i = 0; i < monitor_pkg::WORDS; i++) begin
            mem_next[i] = mem_reg[i];
        end
        if (wr_en && (int'(wr_idx) < monitor_pkg::WORDS)) begin
            mem_next[wr_idx] = wr_data;
        end
        rd_data_next = monitor_pkg::RST_WORD;
        if (int'(rd_idx) < monitor_pkg::WORDS) begin
            rd_data_next = mem_reg[rd_idx];
        end
    end

    // flops, every slot cleared by reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < monitor_pkg::WORDS; i++) begin
                mem_reg[i] <= monitor_pkg::RST_WORD;
            end
            rd_data_reg <= monitor_pkg::RST_WORD;
        end else begin
            for (int i = 0; i < monitor_pkg::WORDS; i++) begin
                mem_reg[i] <= mem_next[i];
            end
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data = rd_data_reg;

endmodule

// [verilog/motor_monitor_readback_regs.sv]
// Summary of operation
// R01: speed estimate word, read only, 2^27 scaled
// R02: supply bus current word, read only
// R03: three phase current words, same scaling
// R04: sense amp gain code, 16 bits, 0..3
// R05: voltage range code, 16 bits, 0..2
// R06: supply voltage word, read only
// R07: phase A detection voltage word, read only
// R08: all 32-bit words reset to zero
// R09: both 16-bit codes reset to zero
// R10: voltage range code sits at 0x472
// R11: host writes ignored, reads have no effects
`timescale 1ns/100ps

module motor_monitor_readback_regs (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // host register access
    input wire monitor_pkg::host_req_s host_req,
    output logic [31:0] host_rdata,
    output logic host_rvalid,
    output logic host_rerr,
    // live values from the control algorithm
    input wire monitor_pkg::mon_upd_s mon_upd
);

    // ==========================================================
    // reset release synchroniser
    logic rst_meta_reg;
    logic rst_sync_reg;

    // two stages so release never lands near a clock edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ==========================================================
    // producer side
    logic [3:0] rd_idx;
    logic [31:0] upd_data;
    logic upd_en;

    // code slots keep only 16 bits so upper bits always read zero
    always_comb begin
        upd_en = mon_upd.valid; // see R01 R02 R03 R06 R07
        upd_data = mon_upd.data;
        if (monitor_pkg::is_code_idx(mon_upd.idx)) begin
            upd_data = {16'h0000, mon_upd.data[15:0]}; // see R04 R05
        end
    end

    // offset decode; 0x472 is the range code slot
    assign rd_idx = monitor_pkg::addr_to_idx(host_req.addr); // see R10

    logic [31:0] store_rdata;

    // storage; the host write port is deliberately absent
    monitor_store u_store (
        .clk(clk),
        .rst_n(rst_sync_reg),
        .wr_en(upd_en),
        .wr_idx(mon_upd.idx),
        .wr_data(upd_data),
        .rd_idx(rd_idx),
        .rd_data(store_rdata)
    );

    // ==========================================================
    // read answer pipeline
    logic rd_p1_reg;
    logic rd_p1_next;
    logic err_p1_reg;
    logic err_p1_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic rerr_reg;
    logic rerr_next;

    // reads have no side effects; writes never reach storage
    always_comb begin
        rd_p1_next = host_req.rd; // see R11
        err_p1_next = host_req.rd && (rd_idx == monitor_pkg::IDX_NONE);
        rvalid_next = rd_p1_reg;
        rerr_next = rd_p1_reg && err_p1_reg;
        rdata_next = rdata_reg;
        if (rd_p1_reg) begin
            // unmapped offsets answer zero with an error flag
            rdata_next = err_p1_reg ? monitor_pkg::RST_WORD : store_rdata;
        end
    end

    // answer flops, cleared by reset
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            rd_p1_reg <= 1'b0;
            err_p1_reg <= 1'b0;
            rdata_reg <= monitor_pkg::RST_WORD; // see R08 R09
            rvalid_reg <= 1'b0;
            rerr_reg <= 1'b0;
        end else begin
            rd_p1_reg <= rd_p1_next;
            err_p1_reg <= err_p1_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            rerr_reg <= rerr_next;
        end
    end

    assign host_rdata = rdata_reg;
    assign host_rvalid = rvalid_reg;
    assign host_rerr = rerr_reg;

    // ==========================================================
    // helper state for checks: shadow of speed, touched flags
    logic [31:0] shadow_speed_reg;
    logic speed_seen_reg;
    logic gain_seen_reg;
    logic hit_speed;
    logic hit_gain;

    assign hit_speed = mon_upd.valid &&
        (mon_upd.idx == monitor_pkg::IDX_SPEED_ESTIMATE);
    assign hit_gain = mon_upd.valid &&
        (mon_upd.idx == monitor_pkg::IDX_SENSE_AMP_GAIN_CODE);

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            shadow_speed_reg <= monitor_pkg::RST_WORD;
            speed_seen_reg <= 1'b0;
            gain_seen_reg <= 1'b0;
        end else begin
            if (hit_speed) begin
                shadow_speed_reg <= mon_upd.data;
                speed_seen_reg <= 1'b1;
            end
            if (hit_gain) begin
                gain_seen_reg <= 1'b1;
            end
        end
    end

    // ==========================================================
    // assertions
    property p_read_latency;
        @(posedge clk) disable iff (!rst_sync_reg)
        host_req.rd |-> ##2 host_rvalid;
    endproperty
    a_read_latency: assert property (p_read_latency) // see R01
        else $error("read answer not two cycles after request");

    property p_speed_value;
        @(posedge clk) disable iff (!rst_sync_reg)
        (host_req.rd && !hit_speed &&
         host_req.addr == monitor_pkg::OFS_SPEED_ESTIMATE)
        |-> ##2 (host_rdata == $past(shadow_speed_reg, 2)) && !host_rerr;
    endproperty
    a_speed_value: assert property (p_speed_value) // see R01
        else $error("speed estimate readback differs from last update");

    property p_speed_reset;
        @(posedge clk) disable iff (!rst_sync_reg)
        (host_req.rd && !speed_seen_reg && !hit_speed &&
         host_req.addr == monitor_pkg::OFS_SPEED_ESTIMATE)
        |-> ##2 host_rdata == 32'h0000_0000;
    endproperty
    a_speed_reset: assert property (p_speed_reset) // see R08
        else $error("speed estimate not zero after reset");

    property p_gain_reset;
        @(posedge clk) disable iff (!rst_sync_reg)
        (host_req.rd && !gain_seen_reg && !hit_gain &&
         host_req.addr == monitor_pkg::OFS_SENSE_AMP_GAIN_CODE)
        |-> ##2 host_rvalid && host_rdata == 32'h0000_0000;
    endproperty
    a_gain_reset: assert property (p_gain_reset) // see R09
        else $error("gain code not zero after reset");

    property p_gain_upper;
        @(posedge clk) disable iff (!rst_sync_reg)
        (host_req.rd &&
         host_req.addr == monitor_pkg::OFS_SENSE_AMP_GAIN_CODE)
        |-> ##2 host_rdata[31:16] == 16'h0000;
    endproperty
    a_gain_upper: assert property (p_gain_upper) // see R04
        else $error("gain code upper half not zero");

    property p_range_slot;
        @(posedge clk) disable iff (!rst_sync_reg)
        (host_req.rd && host_req.addr == 12'h472)
        |-> ##2 host_rvalid && !host_rerr && host_rdata[31:16] == 16'h0000;
    endproperty
    a_range_slot: assert property (p_range_slot) // see R10
        else $error("range code not answered at its offset");

    property p_unmapped;
        @(posedge clk) disable iff (!rst_sync_reg)
        (host_req.rd && rd_idx == monitor_pkg::IDX_NONE)
        |-> ##2 host_rvalid && host_rerr && host_rdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) // see R11
        else $error("unmapped read not flagged");

    property p_write_silent;
        @(posedge clk) disable iff (!rst_sync_reg)
        (host_req.wr && !host_req.rd) |-> ##2 !host_rvalid;
    endproperty
    a_write_silent: assert property (p_write_silent) // see R11
        else $error("write produced an answer");

    property p_write_no_store;
        @(posedge clk) disable iff (!rst_sync_reg)
        (host_req.wr && !hit_speed) |=>
            $stable(u_store.mem_reg[monitor_pkg::IDX_SPEED_ESTIMATE]);
    endproperty
    a_write_no_store: assert property (p_write_no_store) // see R11
        else $error("write disturbed the stored speed word");

endmodule

// [verification/motor_monitor_readback_regs_tb_top.sv]
`timescale 1ns/100ps

module motor_monitor_readback_regs_tb_top;

    // ==========================================================
    // clock, reset and design ports
    logic clk;
    logic arst_n;
    monitor_pkg::host_req_s host_req;
    logic [31:0] host_rdata;
    logic host_rvalid;
    logic host_rerr;
    monitor_pkg::mon_upd_s mon_upd;
    int bad_count;
    int checked;
    logic [11:0] ofs [9];

    motor_monitor_readback_regs DUT (
        .clk(clk),
        .arst_n(arst_n),
        .host_req(host_req),
        .host_rdata(host_rdata),
        .host_rvalid(host_rvalid),
        .host_rerr(host_rerr),
        .mon_upd(mon_upd)
    );

    // 25 MHz clock
    always #20 clk = ~clk;

    // ==========================================================
    // shared compare and port tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one read; the answer stands only between the 1st and 2nd edge
    // after the taking one, so it is looked at just past the 1st
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic er);
        @(posedge clk);
        host_req.rd <= 1'b1;
        host_req.addr <= a;
        @(posedge clk);
        host_req.rd <= 1'b0;
        @(posedge clk);
        #1;
        chk({31'h0, host_rvalid}, 32'h1);
        chk(host_rdata, e);
        chk({31'h0, host_rerr}, {31'h0, er});
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        host_req.wr <= 1'b1;
        host_req.addr <= a;
        host_req.wdata <= d;
        @(posedge clk);
        host_req.wr <= 1'b0;
    endtask

    task automatic upd(input logic [3:0] i, input logic [31:0] d);
        @(posedge clk);
        mon_upd.valid <= 1'b1;
        mon_upd.idx <= i;
        mon_upd.data <= d;
        @(posedge clk);
        mon_upd.valid <= 1'b0;
    endtask

    // code slots keep only the low half, zero-extended on read
    function automatic logic [31:0] expect_of(input int i,
                                              input logic [31:0] d);
        if (i == 5 || i == 6) begin
            return {16'h0000, d[15:0]};
        end
        return d;
    endfunction

    function automatic logic [31:0] pat(input int i);
        return 32'h8765_4321 ^ (32'h0101_0101 * i);
    endfunction

    // ==========================================================
    // verdict, reached from the tests and from the watchdog
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // bounded run: the tests need well under 2000 cycles
    initial begin
        #(40 * 20000);
        bad_count++;
        $display("Error at %0t: watchdog expired", $time);
        close_out();
    end

    // ==========================================================
    // test sequence
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        host_req = '0;
        mon_upd = '0;
        bad_count = 0;
        checked = 0;
        ofs = '{monitor_pkg::OFS_SPEED_ESTIMATE,
                monitor_pkg::OFS_SUPPLY_BUS_CURRENT,
                monitor_pkg::OFS_PHASE_A_CURRENT,
                monitor_pkg::OFS_PHASE_B_CURRENT,
                monitor_pkg::OFS_PHASE_C_CURRENT,
                monitor_pkg::OFS_SENSE_AMP_GAIN_CODE,
                12'h472,
                monitor_pkg::OFS_SUPPLY_VOLTAGE,
                monitor_pkg::OFS_PHASE_A_VOLTAGE_DETECT};
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);

        // every word and code reads zero out of reset
        for (int i = 0; i < 9; i++) begin
            rd(ofs[i], 32'h0000_0000, 1'b0);
        end
        $display("test reset values done");

        // each slot reports what its producer last delivered
        for (int i = 0; i < 9; i++) begin
            upd(i[3:0], pat(i));
        end
        for (int i = 0; i < 9; i++) begin
            rd(ofs[i], expect_of(i, pat(i)), 1'b0);
        end
        $display("test live values done");

        // every gain and range code passes through unchanged
        for (int c = 0; c < 4; c++) begin
            upd(4'h5, 32'hffff_0000 | c);
            rd(ofs[5], c, 1'b0);
        end
        for (int c = 0; c < 3; c++) begin
            upd(4'h6, 32'hffff_0000 | c);
            rd(ofs[6], c, 1'b0);
        end
        $display("test code values done");

        // host writes and repeated reads leave the words alone
        for (int i = 0; i < 9; i++) begin
            upd(i[3:0], pat(i + 3));
            wr(ofs[i], ~pat(i + 3));
            rd(ofs[i], expect_of(i, pat(i + 3)), 1'b0);
            rd(ofs[i], expect_of(i, pat(i + 3)), 1'b0);
        end
        // a producer slot past the last one must leave the last slot alone
        upd(4'h9, 32'hdead_beef);
        rd(ofs[8], pat(11), 1'b0);
        $display("test read only done");

        // a hole in the map answers zero with the error flag
        rd(12'h198, 32'h0000_0000, 1'b1);
        rd(12'h473, 32'h0000_0000, 1'b1);
        rd(ofs[0], pat(3), 1'b0);
        $display("test unmapped done");

        // a second reset clears everything again
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            rd(ofs[i], 32'h0000_0000, 1'b0);
        end
        $display("test second reset done");
        close_out();
    end

endmodule
